// ===== hdl/rcg_pkg.sv
package rcg_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned STRAP_HOLD_MS = 55;
  localparam int unsigned STRAP_HOLD_CYC = (CLK_HZ / 1000) * STRAP_HOLD_MS;

  // ----------------------------------------------------------------
  // Configuration store
  // ----------------------------------------------------------------
  localparam int unsigned CFG_REGS = 253;
  localparam int unsigned GPIO_N = 8;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // Register indices (APB byte address = 4 * index)
  localparam logic [7:0] IDX_GPIO_CFG0 = 8'h00;
  localparam logic [7:0] IDX_TIE_CTRL = 8'h08;
  localparam logic [7:0] IDX_STOP_CLK = 8'h09;
  localparam logic [7:0] IDX_DIFF_EN = 8'h0a;
  localparam logic [7:0] IDX_CMOS_EN = 8'h0b;
  localparam logic [7:0] IDX_STATUS = 8'h0c;
  localparam logic [7:0] IDX_INT_STAT = 8'h0d;
  localparam logic [7:0] IDX_INT_MASK = 8'h0e;
  localparam logic [7:0] IDX_STRAP = 8'h0f;

  // Field positions
  localparam int unsigned TIE_CLR_BIT = 0;
  localparam int unsigned STAT_DONE_BIT = 7;
  localparam int unsigned STRAP_CLK0_BIT = 0;
  localparam int unsigned STRAP_CLK1_BIT = 1;

  // ----------------------------------------------------------------
  // Function codes
  // ----------------------------------------------------------------
  localparam logic [6:0] FN_NONE = 7'h00;
  localparam logic [6:0] FN_LOS0 = 7'h10;
  localparam logic [6:0] FN_LOS3 = 7'h1c;
  localparam logic [6:0] FN_TIE_CLR = 7'h20;
  localparam logic [6:0] FN_STOP_S0_FIRST = 7'h44;
  localparam logic [6:0] FN_STOP_S0_LAST = 7'h47;
  localparam logic [6:0] FN_STOP_S1_FIRST = 7'h4c;
  localparam logic [6:0] FN_STOP_S1_LAST = 7'h4f;
  localparam logic [6:0] FN_DIFF0 = 7'h60;
  localparam logic [6:0] FN_DIFF7 = 7'h6e;
  localparam logic [6:0] FN_CMOS0 = 7'h70;
  localparam logic [6:0] FN_CMOS3 = 7'h76;
  localparam logic [7:0] FN_IRQ_OUT = 8'h80;
  localparam int unsigned DIFF0_GPIO = 2;

  // Master clock selection from straps [1:0]
  typedef enum logic [1:0] {
    RCG_MCLK_RSVD0 = 2'b00,
    RCG_MCLK_RSVD1 = 2'b01,
    RCG_MCLK_20M = 2'b10,
    RCG_MCLK_24M576 = 2'b11
  } rcg_mclk_e;

endpackage : rcg_pkg

// ===== hdl/rcg_cfg_if.sv
`timescale 1ns/100ps
`default_nettype none
// Read/write port from the bus slave into the configuration store
interface rcg_cfg_if;
  logic we;
  logic [7:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport master (output we, output idx, output wdata, input rdata);
  modport store (input we, input idx, input wdata, output rdata);
endinterface : rcg_cfg_if
`default_nettype wire

// ===== hdl/rcg_cfg_store.sv
`timescale 1ns/100ps
`default_nettype none
module rcg_cfg_store #(
  parameter int unsigned DEPTH = rcg_pkg::CFG_REGS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load_otp,
  input wire logic [7:0] otp_value [DEPTH],
  rcg_cfg_if.store bus,
  output logic [7:0] regs [DEPTH]
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] mem_q [DEPTH];

  // OTP image wins over a same-cycle host write; it is a one-shot at start-up
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= rcg_pkg::CFG_RESET;
    end
    else if (load_otp)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= otp_value[i];
    end
    else if (bus.we && (int'(bus.idx) < DEPTH))
    begin
      mem_q[bus.idx] <= bus.wdata;
    end
  end

  assign bus.rdata = (int'(bus.idx) < DEPTH) ? mem_q[bus.idx] : 8'h00;
  assign regs = mem_q;
endmodule : rcg_cfg_store
`default_nettype wire

// ===== hdl/rcg_top.sv
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - After reset release the block starts from its default configuration.
// - All clock output enables come out of reset low.
// - High level on gpio 2 enables differential output zero untouched.
// - Configuration store holds 253 eight-bit registers.
// - At power-up the store loads the one-time-programmable image.
// - Host rewrites configuration registers at run time over the bus.
// - Bits 6:0 of each pin register select the pin function; bit 7 counts only for code 80, matched on all 8 bits.
// - Code zero leaves the pin a plain input, no function.
// - Codes 10,14,18,1c make the pin loss-of-signal for refs 0-3.
// - Loss-of-signal drives reference fail, switching decision and interrupt status.
// - Code 20 is error-clear enable, ORed with the loop control bit.
// - Codes 44-47, 4c-4f drive post-divider stop bits, ORed with register.
// - Even codes 60-6c enable differential outputs 0-6, ORed with register.
// - Block drives a host interrupt line on status changes.
// - Code 6e enables differential 7; even 70-76 enable CMOS outputs 0-3.
// - Straps 1:0 pick master clock: 10 is 20 MHz, 11 24.576 MHz.
// - Code 80 makes the pin an output high while interrupt asserted.
module rcg_top #(
  parameter int unsigned STRAP_HOLD_CYC = rcg_pkg::STRAP_HOLD_CYC,
  parameter int unsigned NGPIO = rcg_pkg::GPIO_N
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] otp_value [rcg_pkg::CFG_REGS],
  input wire logic [NGPIO-1:0] gpio_in,
  output logic [NGPIO-1:0] gpio_out,
  output logic [NGPIO-1:0] gpio_oe_n,
  output logic [7:0] diff_out_en,
  output logic [3:0] cmos_out_en,
  output logic [7:0] post_div_stop,
  output logic tie_clear_en,
  output logic [3:0] ref_fail,
  output logic [3:0] ref_switch_req,
  output logic host_irq,
  output logic [1:0] mclk_sel,
  output logic mclk_sel_valid,
  output logic [4:0] strap_value
);
  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Returns 1 when code sits on a step boundary inside [lo, hi]
  function automatic logic code_in(input logic [6:0] code, input logic [6:0] lo,
                                   input logic [6:0] hi, input logic [6:0] step);
    logic [6:0] off;
    off = code - lo;
    code_in = (code >= lo) && (code <= hi) && ((off % step) == 7'h00);
  endfunction : code_in

  // ----------------------------------------------------------------
  // Start-up sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RCG_ST_LOAD = 2'b00,
    RCG_ST_STRAP = 2'b01,
    RCG_ST_RUN = 2'b10
  } rcg_state_e;

  rcg_state_e state_q;
  logic [31:0] hold_cnt_q;
  logic load_otp;

  assign load_otp = (state_q == RCG_ST_LOAD);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= RCG_ST_LOAD;
      hold_cnt_q <= 32'h0;
    end
    else
    begin
      unique case (state_q)
        RCG_ST_LOAD:
        begin
          state_q <= RCG_ST_STRAP;
        end
        RCG_ST_STRAP:
        begin
          // Count from release; board keeps straps steady meanwhile
          if (hold_cnt_q >= STRAP_HOLD_CYC - 1)
            state_q <= RCG_ST_RUN;
          hold_cnt_q <= hold_cnt_q + 32'h1;
        end
        RCG_ST_RUN:
        begin
          state_q <= RCG_ST_RUN;
        end
        // Unused code: restart from a fresh load rather than hang
        default:
        begin
          state_q <= RCG_ST_LOAD;
        end
      endcase
    end
  end

  // Straps caught once, at the end of the window, then frozen
  logic [4:0] strap_q;
  logic strap_done_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_q <= 5'h00;
      strap_done_q <= 1'b0;
    end
    else if (state_q == RCG_ST_STRAP && hold_cnt_q >= STRAP_HOLD_CYC - 1)
    begin
      strap_q <= {gpio_in[5], gpio_in[4], gpio_in[3], gpio_in[1], gpio_in[0]};
      strap_done_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Configuration store
  // ----------------------------------------------------------------
  rcg_cfg_if cfg ();
  logic [7:0] regs [rcg_pkg::CFG_REGS];

  rcg_cfg_store #(
    .DEPTH(rcg_pkg::CFG_REGS)
  ) u_store (
    .pclk(pclk),
    .presetn(presetn),
    .load_otp(load_otp),
    .otp_value(otp_value),
    .bus(cfg.store),
    .regs(regs)
  );

  // ----------------------------------------------------------------
  // Pin function decode
  // ----------------------------------------------------------------
  logic [3:0] los_pin;
  logic tie_pin;
  logic [7:0] stop_pin;
  logic [7:0] diff_pin;
  logic [3:0] cmos_pin;
  logic [NGPIO-1:0] irq_pin_sel;

  always_comb
  begin
    logic [6:0] code;
    logic [6:0] off;
    code = 7'h00;
    off = 7'h00;
    los_pin = 4'h0;
    tie_pin = 1'b0;
    stop_pin = 8'h00;
    diff_pin = 8'h00;
    cmos_pin = 4'h0;
    irq_pin_sel = '0;
    for (int p = 0; p < NGPIO; p++)
    begin
      code = regs[int'(rcg_pkg::IDX_GPIO_CFG0) + p][6:0];
      if (regs[int'(rcg_pkg::IDX_GPIO_CFG0) + p] == rcg_pkg::FN_IRQ_OUT)
        irq_pin_sel[p] = 1'b1;
      else if (code_in(code, rcg_pkg::FN_LOS0, rcg_pkg::FN_LOS3, 7'h04))
      begin
        off = code - rcg_pkg::FN_LOS0;
        los_pin[off[3:2]] = los_pin[off[3:2]] | gpio_in[p];
      end
      else if (code == rcg_pkg::FN_TIE_CLR)
        tie_pin = tie_pin | gpio_in[p];
      else if (code_in(code, rcg_pkg::FN_STOP_S0_FIRST, rcg_pkg::FN_STOP_S0_LAST, 7'h01))
      begin
        off = code - rcg_pkg::FN_STOP_S0_FIRST;
        stop_pin[off[1:0]] = stop_pin[off[1:0]] | gpio_in[p];
      end
      else if (code_in(code, rcg_pkg::FN_STOP_S1_FIRST, rcg_pkg::FN_STOP_S1_LAST, 7'h01))
      begin
        off = code - rcg_pkg::FN_STOP_S1_FIRST;
        stop_pin[{1'b1, off[1:0]}] = stop_pin[{1'b1, off[1:0]}] | gpio_in[p];
      end
      else if (code_in(code, rcg_pkg::FN_DIFF0, rcg_pkg::FN_DIFF7, 7'h02))
      begin
        off = code - rcg_pkg::FN_DIFF0;
        diff_pin[off[3:1]] = diff_pin[off[3:1]] | gpio_in[p];
      end
      else if (code_in(code, rcg_pkg::FN_CMOS0, rcg_pkg::FN_CMOS3, 7'h02))
      begin
        off = code - rcg_pkg::FN_CMOS0;
        cmos_pin[off[2:1]] = cmos_pin[off[2:1]] | gpio_in[p];
      end
      // Code zero and any unassigned code: plain input, nothing driven
    end
    // Pin 2 reaches differential output zero with no software set-up
    diff_pin[0] = diff_pin[0] | gpio_in[rcg_pkg::DIFF0_GPIO];
  end

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  logic [3:0] int_stat_q;
  // Delayed loss copy gives the rising edges for the sticky status
  logic [3:0] los_q;

  // Enables re-registered every cycle, so pin changes show one cycle later

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      diff_out_en <= 8'h00;
      cmos_out_en <= 4'h0;
      post_div_stop <= 8'h00;
      tie_clear_en <= 1'b0;
    end
    else
    begin
      diff_out_en <= regs[rcg_pkg::IDX_DIFF_EN] | diff_pin;
      cmos_out_en <= regs[rcg_pkg::IDX_CMOS_EN][3:0] | cmos_pin;
      post_div_stop <= regs[rcg_pkg::IDX_STOP_CLK] | stop_pin;
      tie_clear_en <= regs[rcg_pkg::IDX_TIE_CTRL][rcg_pkg::TIE_CLR_BIT] | tie_pin;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      los_q <= 4'h0;
      ref_fail <= 4'h0;
      ref_switch_req <= 4'h0;
    end
    else
    begin
      los_q <= los_pin;
      ref_fail <= los_pin;
      ref_switch_req <= los_pin;
    end
  end

  // Sticky status: a new loss event wins over a same-cycle write-one clear
  logic clr_int;
  logic [3:0] clr_mask;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_stat_q <= 4'h0;
    else
      int_stat_q <= (int_stat_q & ~(clr_int ? clr_mask : 4'h0)) | (los_pin & ~los_q);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      host_irq <= 1'b0;
      gpio_out <= '0;
      gpio_oe_n <= '1;
    end
    else
    begin
      host_irq <= |(int_stat_q & regs[rcg_pkg::IDX_INT_MASK][3:0]);
      gpio_out <= irq_pin_sel & {NGPIO{host_irq}};
      gpio_oe_n <= ~irq_pin_sel;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mclk_sel <= rcg_pkg::RCG_MCLK_RSVD0;
      mclk_sel_valid <= 1'b0;
      strap_value <= 5'h00;
    end
    else
    begin
      mclk_sel <= {strap_q[rcg_pkg::STRAP_CLK1_BIT], strap_q[rcg_pkg::STRAP_CLK0_BIT]};
      mclk_sel_valid <= strap_done_q && strap_q[rcg_pkg::STRAP_CLK1_BIT];
      strap_value <= strap_q;
    end
  end

  // ----------------------------------------------------------------
  // APB slave, one wait-free access phase
  // ----------------------------------------------------------------
  logic acc;
  logic [9:0] widx;
  logic mapped;
  assign acc = psel && penable && pready;
  assign widx = paddr[11:2];
  assign mapped = (int'(widx) < rcg_pkg::CFG_REGS);
  assign clr_int = acc && pwrite && (widx == {2'b00, rcg_pkg::IDX_INT_STAT});
  assign clr_mask = pwdata[3:0];

  // Status and strap views are read-only; interrupt status is write-one-clear
  assign cfg.we = acc && pwrite && mapped && (widx != {2'b00, rcg_pkg::IDX_INT_STAT})
                  && (widx != {2'b00, rcg_pkg::IDX_STATUS})
                  && (widx != {2'b00, rcg_pkg::IDX_STRAP});
  assign cfg.idx = widx[7:0];
  assign cfg.wdata = pwdata[7:0];

  // Ready asserted in the access phase so every access takes two cycles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= psel && !penable;
      // Out-of-range index answers with an error and reads as zero
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite)
      begin
        if (!mapped)
          prdata <= 32'h0;
        else if (widx == {2'b00, rcg_pkg::IDX_INT_STAT})
          prdata <= {28'h0, int_stat_q};
        else if (widx == {2'b00, rcg_pkg::IDX_STATUS})
          prdata <= {24'h0, strap_done_q, 3'h0, los_q};
        else if (widx == {2'b00, rcg_pkg::IDX_STRAP})
          prdata <= {27'h0, strap_q};
        else
          prdata <= {24'h0, cfg.rdata};
      end
    end
  end
endmodule : rcg_top
`default_nettype wire

// ===== test/rcg_top_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module rcg_top_asserts #(
  parameter int unsigned STRAP_HOLD_CYC = rcg_pkg::STRAP_HOLD_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] gpio_in,
  input wire logic [7:0] diff_out_en,
  input wire logic [3:0] cmos_out_en,
  input wire logic [7:0] post_div_stop,
  input wire logic tie_clear_en,
  input wire logic [3:0] ref_fail,
  input wire logic [3:0] ref_switch_req,
  input wire logic [1:0] mclk_sel,
  input wire logic mclk_sel_valid,
  input wire logic [4:0] strap_value
);
  // ----------------------------------------------------------------
  // Cycles since release, saturating so it never wraps in long runs
  // ----------------------------------------------------------------
  logic [31:0] cnt_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cnt_q <= '0;
    else if (cnt_q < STRAP_HOLD_CYC + 8)
      cnt_q <= cnt_q + 32'h1;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_outputs_off_reset: assert property ($rose(presetn) |->
    diff_out_en == 8'h00 && cmos_out_en == 4'h0 && post_div_stop == 8'h00)
    else $error("clock outputs enabled out of reset");
  chk_pready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no answer in the access cycle");
  chk_pready_single: assert property (pready |=> !pready)
    else $error("pready held more than one cycle");
  chk_slverr_range: assert property (pready |-> pslverr == (paddr[11:2] >= 10'd253))
    else $error("error response does not match register range");
  chk_los_copy: assert property (ref_switch_req == ref_fail)
    else $error("switch request differs from reference fail");
  chk_mclk_strap: assert property (mclk_sel_valid |-> mclk_sel == strap_value[1:0] && mclk_sel[1])
    else $error("master clock select disagrees with straps");
  chk_strap_held: assert property (mclk_sel_valid |=> mclk_sel_valid && $stable(strap_value))
    else $error("captured straps changed");
  chk_strap_early: assert property (mclk_sel_valid |-> cnt_q >= STRAP_HOLD_CYC)
    else $error("straps captured before the hold window ended");
  chk_strap_late: assert property (cnt_q == STRAP_HOLD_CYC + 4 |-> strap_value[1] == mclk_sel_valid)
    else $error("straps not captured after the hold window");
  chk_gpio2_diff0: assert property (gpio_in[2] [*4] |-> diff_out_en[0])
    else $error("pin two does not enable differential output zero");

  cover property (pready && pslverr);
  cover property (mclk_sel_valid);
  cover property (|ref_fail);
  cover property (tie_clear_en);
endmodule : rcg_top_asserts

bind rcg_top rcg_top_asserts #(.STRAP_HOLD_CYC(STRAP_HOLD_CYC)) rcg_top_asserts_inst (
  .pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .gpio_in, .diff_out_en,
  .cmos_out_en, .post_div_stop, .tie_clear_en, .ref_fail, .ref_switch_req, .mclk_sel,
  .mclk_sel_valid, .strap_value
);
`default_nettype wire

// ===== test/rcg_board_model.sv
`timescale 1ns/100ps
`default_nettype none
module rcg_board_model #(
  parameter int unsigned HOLD = 50
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [4:0] straps,
  input wire logic [7:0] pins,
  output logic [7:0] gpio_in
);
  int unsigned cnt_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cnt_q <= 0;
    else if (cnt_q < HOLD + 8)
      cnt_q <= cnt_q + 1;

  // Straps held through reset and past the window, then the host owns the pins
  always_comb
  begin
    gpio_in = pins;
    if (!presetn || cnt_q < HOLD + 4)
      {gpio_in[5], gpio_in[4], gpio_in[3], gpio_in[1], gpio_in[0]} = straps;
  end
endmodule : rcg_board_model
`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int unsigned HOLD_CYC = 50;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tie_clear_en, host_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] otp [rcg_pkg::CFG_REGS];
  logic [7:0] pins, gpio_in, gpio_out, gpio_oe_n, diff_out_en, post_div_stop;
  logic [3:0] cmos_out_en, ref_fail, ref_switch_req;
  logic [1:0] mclk_sel;
  logic mclk_sel_valid;
  logic [4:0] strap_value, straps;
  logic [24:0] outs;
  int miscompares = 0;
  int cmp_count = 0;

  assign outs = {diff_out_en, cmos_out_en, post_div_stop, tie_clear_en, ref_fail};

  rcg_top #(.STRAP_HOLD_CYC(HOLD_CYC)) rcg_top_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .otp_value(otp), .gpio_in, .gpio_out, .gpio_oe_n, .diff_out_en,
    .cmos_out_en, .post_div_stop, .tie_clear_en, .ref_fail, .ref_switch_req,
    .host_irq, .mclk_sel, .mclk_sel_valid, .strap_value
  );
  rcg_board_model #(.HOLD(HOLD_CYC)) rcg_board_model_inst (
    .pclk, .presetn, .straps, .pins, .gpio_in
  );

  always #25 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      miscompares++;
      results();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic do_reset(input logic [4:0] s);
    @(posedge pclk);
    presetn <= 1'b0;
    straps <= s;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(32'(outs), 32'h0);
    chk(32'(gpio_oe_n), 32'hff);
    repeat (HOLD_CYC + 8) @(posedge pclk);
    chk(32'({mclk_sel_valid, mclk_sel, strap_value}), 32'({s[1], s[1:0], s}));
  endtask : do_reset

  // Ref bits 3:0, tie 4, stop 12:5, cmos 16:13, diff 24:17
  function automatic logic [24:0] fn_map(input logic [6:0] c);
    logic [24:0] v;
    v = '0;
    if (c[6:4] == 3'h1 && c[1:0] == 2'b00)
      v[c[3:2]] = 1'b1;
    if (c == 7'h20)
      v[4] = 1'b1;
    if (c[6:3] == 4'h8 && c[2])
      v[5 + c[1:0]] = 1'b1;
    if (c[6:3] == 4'h9 && c[2])
      v[9 + c[1:0]] = 1'b1;
    if (c[6:3] == 4'he && !c[0])
      v[13 + c[2:1]] = 1'b1;
    if (c[6:4] == 3'h6 && !c[0])
      v[17 + c[3:1]] = 1'b1;
    return v;
  endfunction : fn_map

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] rd, rv;
    logic [24:0] base;
    logic er;
    logic [9:0] idx;
    logic [4:0] sv;
    int unsigned p;
    void'($urandom(32'hc182));
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pins = 8'h00;
    straps = 5'h00;
    foreach (otp[i])
      otp[i] = (i < 16) ? 8'h00 : 8'($urandom);
    do_reset(5'h15);
    sv = 5'($urandom) | 5'h02;
    do_reset(sv);
    apb(1'b1, 10'h00c, 32'h0, rd, er);
    apb(1'b0, 10'h00c, 32'h0, rd, er);
    chk(rd, 32'h80);
    apb(1'b1, 10'h00f, 32'(~sv), rd, er);
    apb(1'b0, 10'h00f, 32'h0, rd, er);
    chk(rd, 32'(sv));
    pins[2] <= 1'b1;
    repeat (5) @(posedge pclk);
    chk(32'(diff_out_en), 32'h01);
    pins[2] <= 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      idx = 10'(16 + i * 37 + $urandom_range(36));
      apb(1'b0, idx, 32'h0, rd, er);
      chk(rd, {24'h0, otp[idx]});
      rv = $urandom;
      apb(1'b1, idx, rv, rd, er);
      apb(1'b0, idx, 32'h0, rd, er);
      chk(rd, {24'h0, rv[7:0]});
    end
    apb(1'b0, 10'd252, 32'h0, rd, er);
    chk({er, rd[30:0]}, {1'b0, 23'h0, otp[252]});
    apb(1'b0, 10'd253, 32'h0, rd, er);
    chk({er, rd[30:0]}, 32'h80000000);
    rv = $urandom;
    for (int i = 0; i < 4; i++)
      apb(1'b1, 10'h008 + 10'(i), 32'(rv[8 * i +: 8]), rd, er);
    base = {rv[23:16], rv[27:24], rv[15:8], rv[0], 4'h0};
    for (int c = 0; c < 128; c++)
    begin
      p = 3 + $urandom_range(4);
      apb(1'b1, 10'(p), 32'(c), rd, er);
      pins[p] <= 1'b1;
      repeat (5) @(posedge pclk);
      chk(32'(outs), 32'(base | fn_map(7'(c))));
      pins[p] <= 1'b0;
      repeat (5) @(posedge pclk);
      chk(32'(outs), 32'(base));
      apb(1'b1, 10'(p), 32'h0, rd, er);
    end
    apb(1'b1, 10'h00d, 32'hff, rd, er);
    apb(1'b1, 10'h00e, 32'h01, rd, er);
    apb(1'b1, 10'h003, 32'h10, rd, er);
    apb(1'b1, 10'h004, 32'h80, rd, er);
    pins[3] <= 1'b1;
    repeat (5) @(posedge pclk);
    chk(32'({host_irq, gpio_oe_n[4], gpio_out[4], ref_fail[0]}), 32'hb);
    apb(1'b0, 10'h00d, 32'h0, rd, er);
    chk(rd, 32'h1);
    pins[3] <= 1'b0;
    repeat (5) @(posedge pclk);
    chk(32'({host_irq, gpio_oe_n[4], gpio_out[4], ref_fail[0]}), 32'ha);
    apb(1'b1, 10'h00d, 32'h01, rd, er);
    repeat (5) @(posedge pclk);
    chk(32'({host_irq, gpio_oe_n[4], gpio_out[4], ref_fail[0]}), 32'h0);
    apb(1'b0, 10'h00d, 32'h0, rd, er);
    chk(rd, 32'h0);
    results();
  end
endmodule : testbench
`default_nettype wire
